// file: tw_regs.svh
// Timing and field constants for the two-wire bus controller
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

`define TW_CLK_NS     4
`define TW_LOW_NS     1300
`define TW_HIGH_NS    1200
`define TW_BUF_NS     1300
`define TW_LOW_CYC    ((`TW_LOW_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_HIGH_CYC   ((`TW_HIGH_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_BUF_CYC    ((`TW_BUF_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_CNT_W      10
`define TW_ACK_IDX    4'h8
`define TW_MSB        7
`define TW_GCALL_ADDR 8'h00

`endif

// file: tw_pkg.sv
// Types shared by the two-wire bus controller modules
package tw_pkg;

	typedef enum logic [1:0] {
		TW_OP_START,
		TW_OP_WRITE,
		TW_OP_READ,
		TW_OP_STOP
	} tw_op_type;

	typedef struct packed {
		tw_op_type  op;
		logic [7:0] data;
		logic       last;
	} tw_cmd_type;

	typedef struct packed {
		logic [7:0] data;
		logic       nack;
		logic       arb_lost;
		logic       bus_err;
	} tw_rsp_type;

	typedef struct packed {
		logic scl;
		logic sda;
		logic start_det;
		logic stop_det;
		logic busy;
	} tw_line_type;

endpackage

// file: tw_timer.sv
// Reloadable down-counter timing each bus phase
`include "tw_regs.svh"

module tw_timer
	import tw_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 nrst,
	input  wire logic                 load,
	input  wire logic [`TW_CNT_W-1:0] len,
	output logic                      done
);

	logic [`TW_CNT_W-1:0] cnt;

	// Load wins so a retrigger always restarts the phase
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= len;
		end else if (cnt != '0) begin
			cnt <= cnt - `TW_CNT_W'(1);
		end
	end

	assign done = (cnt == '0) && !load;

endmodule

// file: tw_line_sync.sv
// Line synchronisers, Start/Stop detection and bus busy tracking
`include "tw_regs.svh"

module tw_line_sync
	import tw_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  nrst,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	output tw_line_type line
);

	logic [1:0]           scl_ff;
	logic [1:0]           sda_ff;
	logic                 scl_d;
	logic                 sda_d;
	logic                 busy;
	logic [`TW_CNT_W-1:0] free_cnt;
	logic                 start_det;
	logic                 stop_det;

	// Two stages; only stage 1 reads stage 0
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_ff <= {scl_ff[0], scl_in};
			sda_ff <= {sda_ff[0], sda_in};
			scl_d  <= scl_ff[1];
			sda_d  <= sda_ff[1];
		end
	end

	// SDA edges while SCL stays high
	assign start_det = scl_d && scl_ff[1] && sda_d && !sda_ff[1];
	assign stop_det  = scl_d && scl_ff[1] && !sda_d && sda_ff[1];

	// Busy from Start until bus-free time after Stop
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy     <= 1'b0;
			free_cnt <= '0;
		end else if (start_det) begin
			busy     <= 1'b1;
			free_cnt <= '0;
		end else if (stop_det) begin
			free_cnt <= `TW_CNT_W'(`TW_BUF_CYC);
		end else if (free_cnt != '0) begin
			free_cnt <= free_cnt - `TW_CNT_W'(1);
			if (free_cnt == `TW_CNT_W'(1)) begin
				busy <= 1'b0;
			end
		end
	end

	assign line.scl       = scl_ff[1];
	assign line.sda       = sda_ff[1];
	assign line.start_det = start_det;
	assign line.stop_det  = stop_det;
	assign line.busy      = busy;

endmodule

// file: tw_master.sv
// Two-wire bus master controller driving the device's SDA and SCL pins
`include "tw_regs.svh"

module tw_master
	import tw_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire tw_cmd_type cmd,
	output logic            rsp_valid,
	output tw_rsp_type      rsp,
	output logic            bus_busy,
	output logic            gcall_sent,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_HOLD,
		ST_RS_PREP,
		ST_START_HI,
		ST_START_FALL,
		ST_BIT_LO,
		ST_BIT_HI,
		ST_STOP_LO,
		ST_STOP_HI,
		ST_STOP_END
	} tw_state_type;

	tw_state_type         state;
	tw_state_type         next_state;
	tw_line_type          line;
	logic                 phase_enter;
	logic                 hi_seen;
	logic                 tmr_load;
	logic                 tmr_done;
	logic [`TW_CNT_W-1:0] tmr_len;
	logic                 wait_hi;
	logic [7:0]           shreg;
	logic [7:0]           next_shreg;
	logic [3:0]           bit_idx;
	logic [3:0]           next_bit_idx;
	logic                 is_read;
	logic                 next_is_read;
	logic                 last;
	logic                 next_last;
	logic                 first_byte;
	logic                 next_first_byte;
	logic                 next_scl_oe;
	logic                 next_sda_oe;
	logic                 next_rsp_valid;
	tw_rsp_type           next_rsp;
	logic                 next_gcall;
	logic                 my_bit;

	// Level this end puts on SDA for a given bit slot
	function automatic logic drive_bit(
		input logic       rd,
		input logic [3:0] idx,
		input logic       lst,
		input logic [7:0] sr
	);
		logic b;
		if (idx == `TW_ACK_IDX) begin
			b = rd ? lst : 1'b1;
		end else begin
			b = rd ? 1'b1 : sr[`TW_MSB];
		end
		return b;
	endfunction

	tw_line_sync u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.line     (line)
	);

	// Phase timer; reloads while waiting for SCL to go high
	assign wait_hi  = (state == ST_START_HI) || (state == ST_BIT_HI) ||
		(state == ST_STOP_HI);
	assign tmr_load = phase_enter || (wait_hi && !line.scl && !hi_seen);
	assign tmr_len  = ((state == ST_BIT_LO) || (state == ST_RS_PREP) ||
		(state == ST_STOP_LO)) ? `TW_CNT_W'(`TW_LOW_CYC) :
		`TW_CNT_W'(`TW_HIGH_CYC);

	tw_timer u_timer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.load     (tmr_load),
		.len      (tmr_len),
		.done     (tmr_done)
	);

	assign my_bit = drive_bit(is_read, bit_idx, last, shreg);

	// New commands wait for the bus to be free or held by us
	assign cmd_ready = ((state == ST_IDLE) && !line.busy) ||
		(state == ST_HOLD);
	assign bus_busy  = line.busy;

	// Sequencer for Start, bits, acknowledge and Stop
	always_comb begin
		next_state      = state;
		next_scl_oe     = scl_oe;
		next_sda_oe     = sda_oe;
		next_shreg      = shreg;
		next_bit_idx    = bit_idx;
		next_is_read    = is_read;
		next_last       = last;
		next_first_byte = first_byte;
		next_rsp_valid  = 1'b0;
		next_rsp        = rsp;
		next_gcall      = 1'b0;
		case (state)
			ST_IDLE: begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
				if (cmd_valid && cmd_ready) begin
					if (cmd.op == TW_OP_START) begin
						next_state = ST_START_HI;
					end else begin
						// Nothing to do without owning the bus
						next_rsp       = '{data: 8'h00, nack: 1'b0,
							arb_lost: 1'b0, bus_err: 1'b1};
						next_rsp_valid = 1'b1;
					end
				end
			end
			ST_HOLD: begin
				// SCL held low stalls the bus between commands
				if (cmd_valid) begin
					next_bit_idx = 4'h0;
					case (cmd.op)
						TW_OP_START: next_state = ST_RS_PREP;
						TW_OP_WRITE: begin
							next_state   = ST_BIT_LO;
							next_shreg   = cmd.data;
							next_is_read = 1'b0;
							if (first_byte && cmd.data == `TW_GCALL_ADDR) begin
								next_gcall = 1'b1;
							end
						end
						TW_OP_READ: begin
							next_state   = ST_BIT_LO;
							next_shreg   = 8'h00;
							next_is_read = 1'b1;
							next_last    = cmd.last;
						end
						default: next_state = ST_STOP_LO;
					endcase
				end
			end
			ST_RS_PREP: begin
				// Release SDA while SCL is still low
				next_sda_oe = 1'b0;
				if (tmr_done) begin
					next_state = ST_START_HI;
				end
			end
			ST_START_HI: begin
				next_scl_oe = 1'b0;
				if (hi_seen && !line.sda) begin
					next_state     = ST_IDLE;
					next_rsp       = '{data: 8'h00, nack: 1'b0,
						arb_lost: 1'b1, bus_err: 1'b0};
					next_rsp_valid = 1'b1;
				end else if (tmr_done) begin
					next_sda_oe = 1'b1;
					next_state  = ST_START_FALL;
				end
			end
			ST_START_FALL: begin
				if (tmr_done) begin
					next_scl_oe     = 1'b1;
					next_first_byte = 1'b1;
					next_state      = ST_HOLD;
					next_rsp        = '0;
					next_rsp_valid  = 1'b1;
				end
			end
			ST_BIT_LO: begin
				// SDA moves one cycle after SCL was pulled low
				if (phase_enter) begin
					next_sda_oe = !my_bit;
				end
				if (tmr_done) begin
					next_state = ST_BIT_HI;
				end
			end
			ST_BIT_HI: begin
				next_scl_oe = 1'b0;
				if (hi_seen && (line.start_det || line.stop_det)) begin
					next_state     = ST_IDLE;
					next_rsp       = '{data: shreg, nack: 1'b0,
						arb_lost: 1'b0, bus_err: 1'b1};
					next_rsp_valid = 1'b1;
				end else if (hi_seen && my_bit && !line.sda && !is_read &&
					bit_idx != `TW_ACK_IDX) begin
					next_state     = ST_IDLE;
					next_rsp       = '{data: shreg, nack: 1'b0,
						arb_lost: 1'b1, bus_err: 1'b0};
					next_rsp_valid = 1'b1;
				end else if (tmr_done || (hi_seen && !line.scl)) begin
					// Another master ending high early shortens it
					next_scl_oe = 1'b1;
					if (bit_idx == `TW_ACK_IDX) begin
						next_state      = ST_HOLD;
						next_first_byte = 1'b0;
						next_rsp        = '{data: shreg, nack: line.sda,
							arb_lost: 1'b0, bus_err: 1'b0};
						next_rsp_valid  = 1'b1;
					end else begin
						next_shreg   = {shreg[6:0], line.sda};
						next_bit_idx = bit_idx + 4'h1;
						next_state   = ST_BIT_LO;
					end
				end
			end
			ST_STOP_LO: begin
				next_sda_oe = 1'b1;
				if (tmr_done) begin
					next_state = ST_STOP_HI;
				end
			end
			ST_STOP_HI: begin
				next_scl_oe = 1'b0;
				if (tmr_done) begin
					next_sda_oe = 1'b0;
					next_state  = ST_STOP_END;
				end
			end
			default: begin
				if (tmr_done) begin
					next_state     = ST_IDLE;
					next_rsp       = '0;
					next_rsp_valid = 1'b1;
				end
			end
		endcase
	end

	// State register and phase entry pulse
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state       <= ST_IDLE;
			phase_enter <= 1'b0;
		end else begin
			state       <= next_state;
			phase_enter <= (next_state != state);
		end
	end

	// SCL seen high in the current phase
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hi_seen <= 1'b0;
		end else if (next_state != state) begin
			hi_seen <= 1'b0;
		end else if (wait_hi && line.scl) begin
			hi_seen <= 1'b1;
		end
	end

	// Byte shifter and slot bookkeeping
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shreg      <= 8'h00;
			bit_idx    <= 4'h0;
			is_read    <= 1'b0;
			last       <= 1'b0;
			first_byte <= 1'b0;
		end else begin
			shreg      <= next_shreg;
			bit_idx    <= next_bit_idx;
			is_read    <= next_is_read;
			last       <= next_last;
			first_byte <= next_first_byte;
		end
	end

	// Open-drain enables; the pin only ever pulls low
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// Answer to each command, one-cycle pulse
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid  <= 1'b0;
			rsp        <= '0;
			gcall_sent <= 1'b0;
		end else begin
			rsp_valid  <= next_rsp_valid;
			rsp        <= next_rsp;
			gcall_sent <= next_gcall;
		end
	end

endmodule

// file: tw_monitor.sv
// Port-level protocol checker for the two-wire bus master
module tw_monitor
	import tw_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire tw_cmd_type cmd,
	input wire logic       rsp_valid,
	input wire tw_rsp_type rsp,
	input wire logic       bus_busy,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	tw_op_type  op_q;
	logic       last_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// Clock releases per command; lags the release by one edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt    <= 4'h0;
			op_q   <= TW_OP_STOP;
			last_q <= 1'b0;
		end else if (cmd_valid && cmd_ready) begin
			cnt    <= 4'h0;
			op_q   <= cmd.op;
			last_q <= cmd.last;
		end else if ($fell(scl_oe)) begin
			cnt <= cnt + 4'h1;
		end
	end

	chk_open_drain: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	chk_idle_refuse: assert property (cmd_valid && cmd_ready && !scl_oe &&
		cmd.op != TW_OP_START |=> rsp_valid && rsp.bus_err)
		else $error("idle command not refused");
	chk_busy_start: assert property ($fell(sda_in) && scl_in &&
		$past(scl_in) |-> ##[1:6] bus_busy)
		else $error("start not marked busy");
	chk_busy_hold: assert property ($rose(sda_in) && scl_in &&
		$past(scl_in) |-> ##300 bus_busy ##[1:40] !bus_busy)
		else $error("bus free time wrong");
	chk_nine_pulses: assert property (rsp_valid && !rsp.bus_err &&
		!rsp.arb_lost && op_q inside {TW_OP_WRITE, TW_OP_READ}
		|-> cnt == 4'h9)
		else $error("byte not nine clocks");
	chk_ack_free: assert property (!scl_oe && !$past(scl_oe) &&
		cnt == 4'h9 && op_q == TW_OP_WRITE |-> !sda_oe)
		else $error("data held in ack slot");
	chk_last_nack: assert property (!scl_oe && !$past(scl_oe) &&
		cnt == 4'h9 && op_q == TW_OP_READ && last_q |-> !sda_oe)
		else $error("last byte acked");
	chk_read_ack: assert property (!scl_oe && !$past(scl_oe) &&
		cnt == 4'h9 && op_q == TW_OP_READ && !last_q |-> sda_oe)
		else $error("read byte not acked");
	chk_read_free: assert property (!scl_oe && !$past(scl_oe) &&
		cnt inside {[4'h1:4'h8]} && op_q == TW_OP_READ |-> !sda_oe)
		else $error("data line held while reading");
	chk_stretch_wait: assert property ((!scl_oe && !scl_in)[*4]
		|=> !scl_oe)
		else $error("stretched clock overridden");
endmodule

// file: tw_slave_model.sv
// Behavioural open-drain slave on the two-wire bus
module tw_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] tx_byte,
	input  wire logic       stretch,
	output logic            scl_pull,
	output logic            sda_pull,
	output logic [7:0]      rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sr    = 8'h00;
	logic [7:0] tx    = 8'h00;
	logic       sel   = 1'b0;
	logic       rd    = 1'b0;
	logic       first = 1'b0;
	logic       mack  = 1'b0;
	int         n     = 0;

	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		rx_byte  = 8'h00;
	end
	// Start restarts framing, Stop deselects
	always @(negedge sda) if (scl) begin
		n = 0;
		first = 1'b1;
		sel = 1'b0;
	end
	always @(posedge sda) if (scl) sel = 1'b0;
	// Sample only in the high phase
	always @(posedge scl) begin
		if (n < 8) sr = {sr[6:0], sda};
		if (n == 8) mack = !sda;
		n = n + 1;
	end
	// Drive only in the low phase, a little after the fall
	always @(negedge scl) begin
		// Settle before the bench may load the next byte
		#1;
		if (n == 8) begin
			if (first) sel = sr[7:1] == ADDR || sr == 8'h00;
			if (first) rd = sr[0] && sr[7:1] == ADDR;
			if (!first && sel && !rd) rx_byte = sr;
			sda_pull = sel && (first || !rd);
		end else if (n == 9) begin
			if (rd && !mack) sel = 1'b0;
			n = 0;
			first = 1'b0;
			tx = tx_byte;
			sda_pull = sel && rd && !tx_byte[7];
		end else begin
			sda_pull = sel && rd && !first && !tx[7 - n];
		end
	end
	// Slow slave: hold past the master's own low time
	always @(negedge scl) if (stretch) begin
		scl_pull = 1'b1;
		#1600;
		scl_pull = 1'b0;
	end
endmodule

// file: tw_master_tb.sv
// Self-checking bench for the two-wire bus master
module tw_master_tb
	import tw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ADDR = 7'h2a;
	logic       core_clk  = 1'b0;
	logic       nrst      = 1'b0;
	logic       cmd_valid = 1'b0;
	tw_cmd_type cmd       = '0;
	logic       stretch   = 1'b0;
	logic       gc_seen   = 1'b0;
	logic [7:0] tx_byte   = 8'h00;
	logic [7:0] b, t1, t2, rx_byte;
	logic       cmd_ready, rsp_valid, bus_busy, gcall_sent;
	logic       scl_out, scl_oe, sda_out, sda_oe, s_scl, s_sda;
	tw_rsp_type rsp;
	tw_rsp_type q[$];
	bit         qd[$];
	int         error_cnt  = 0;
	int         n_compared = 0;
	// Open-drain wires with pull-ups
	wire        scl_in = !(scl_oe || s_scl);
	wire        sda_in = !(sda_oe || s_sda);

	always #2 core_clk = !core_clk;

	tw_master u_dut (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd,
		.rsp_valid, .rsp, .bus_busy, .gcall_sent, .scl_in, .scl_out,
		.scl_oe, .sda_in, .sda_out, .sda_oe);
	tw_slave_model #(.ADDR(ADDR)) u_slave (.scl(scl_in), .sda(sda_in),
		.tx_byte, .stretch, .scl_pull(s_scl), .sda_pull(s_sda), .rx_byte);

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Reads ignore the ack flag, writes ignore the data
	task automatic cmp_rsp(input tw_rsp_type e, input tw_rsp_type g,
		input bit rd);
		n_compared++;
		if (rd) g.nack = e.nack;
		else g.data = e.data;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_val(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Note the answer, offer the command, wait for the answer
	task automatic xfer(input tw_op_type op, input logic [7:0] d,
		input logic l, input logic [7:0] ed, input logic en, input logic eb);
		int k;
		q.push_back('{ed, en, 1'b0, eb});
		qd.push_back(op == TW_OP_READ);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd = '{op, d, l};
		for (k = 0; k < 3000 && cmd_ready !== 1'b1; k++) @(negedge core_clk);
		if (k == 3000) begin
			error_cnt++;
			close_out();
		end
		@(negedge core_clk);
		cmd_valid = 1'b0;
		for (k = 0; k < 12000 && q.size() != 0; k++) @(negedge core_clk);
		if (k == 12000) begin
			error_cnt++;
			close_out();
		end
	endtask

	// Answers are settled by the falling edge
	always @(negedge core_clk) begin
		if (gcall_sent === 1'b1) gc_seen = 1'b1;
		if (rsp_valid === 1'b1 && q.size() == 0) cmp_rsp('1, rsp, 1'b0);
		else if (rsp_valid === 1'b1) cmp_rsp(q.pop_front(), rsp, qd.pop_front());
	end

	initial begin
		b = $urandom(32'hefaf);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		// Idle: anything but a Start is refused
		for (int i = 1; i < 4; i++)
			xfer(tw_op_type'(i), 8'h55, 1'b0, 8'h00, 1'b0, 1'b1);
		// Write, repeated Start, read two bytes, slow slave
		stretch = 1'b1;
		b = $urandom();
		t1 = $urandom();
		t2 = ~t1;
		tx_byte = t1;
		xfer(TW_OP_START, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		xfer(TW_OP_WRITE, {ADDR, 1'b0}, 1'b0, 8'h00, 1'b0, 1'b0);
		xfer(TW_OP_WRITE, b, 1'b0, 8'h00, 1'b0, 1'b0);
		cmp_val(b, rx_byte);
		xfer(TW_OP_START, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		xfer(TW_OP_WRITE, {ADDR, 1'b1}, 1'b0, 8'h00, 1'b0, 1'b0);
		tx_byte = t2;
		xfer(TW_OP_READ, 8'h00, 1'b0, t1, 1'b0, 1'b0);
		xfer(TW_OP_READ, 8'h00, 1'b1, t2, 1'b0, 1'b0);
		xfer(TW_OP_STOP, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		// Nobody answers a foreign address
		stretch = 1'b0;
		xfer(TW_OP_START, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		xfer(TW_OP_WRITE, {ADDR ^ 7'h01, 1'b0}, 1'b0, 8'h00, 1'b1, 1'b0);
		cmp_val(8'h00, {7'h00, gc_seen});
		xfer(TW_OP_STOP, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		// General call is acked and flagged
		xfer(TW_OP_START, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		xfer(TW_OP_WRITE, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		cmp_val(8'h01, {7'h00, gc_seen});
		xfer(TW_OP_STOP, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		close_out();
	end
endmodule

bind tw_master tw_monitor u_mon (.core_clk, .nrst, .cmd_valid, .cmd_ready,
	.cmd, .rsp_valid, .rsp, .bus_busy, .scl_in, .scl_out, .scl_oe, .sda_in,
	.sda_out, .sda_oe);
